// file: core/ssb_pkg.sv
// package for the synchronous burst sram port
package ssb_pkg;
	localparam int BURST_BITS = 2;
	localparam int LANE_BITS = 8;
	localparam logic [1:0] BURST_STEP = 2'h1;
	localparam logic [1:0] BURST_ZERO = 2'h0;

	typedef enum logic {SSB_READ, SSB_WRITE} ssb_kind_t;

	typedef struct packed {
		logic selected;
		ssb_kind_t kind;
	} ssb_cyc_t;
endpackage

// file: core/ssb_port.sv
// synchronous pipelined sram port with burst counter and byte lanes
// Functional notes
// [R01] Data drivers enabled only while output enable low; asynchronous gating.
// [R02] Advance/load low at edge captures external address as new access start.
// [R03] Advance/load high steps burst counter from the loaded address.
// [R04] Read/write select ignored during advance; burst keeps loaded cycle type.
// [R05] Burst order select low means linear order, high means interleaved.
// [R06] Controller keeps burst order select constant while accesses run.
// [R07] Data bus split into byte lanes, each with its byte write control.
// [R08] One parity bit per lane on parity variants; unused on 32-bit variant.
// [R09] On load, read/write low selects write, high selects read.
// [R10] Writes store only lanes whose byte write enables are low.
// [R11] Clock enable high freezes all internal state.
// [R12] Three chip selects sampled only on load; all asserted selects access.
// [R13] Counter changes low two address bits: linear add or interleaved xor.
`timescale 1ns/1ps
`default_nettype none
module ssb_port
	import ssb_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int LANES = 4,
	parameter int PARITY = 1
) (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic ADVANCE_LOAD_N,
	input wire logic READ_WRITE_N,
	input wire logic [LANES-1:0] BYTE_WRITE_N,
	input wire logic CLOCK_ENABLE_N,
	input wire logic CHIP_SELECT_N,
	input wire logic CHIP_SELECT_SECOND_N,
	input wire logic CHIP_SELECT_HIGH,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic BURST_ORDER_SELECT,
	input wire logic [LANES*(LANE_BITS+PARITY)-1:0] DATA_IN,
	output logic [LANES*(LANE_BITS+PARITY)-1:0] DATA_OUT,
	output logic [LANES*(LANE_BITS+PARITY)-1:0] DATA_OE
);
	localparam int LW = LANE_BITS + PARITY;
	localparam int DW = LANES * LW;
	localparam int DEPTH = 1 << ADDR_W;

	logic [DW-1:0] mem [DEPTH];
	logic [ADDR_W-1:0] base_r, base_nxt;
	logic [BURST_BITS-1:0] cnt_r, cnt_nxt;
	ssb_cyc_t cyc_r, cyc_nxt;
	logic active_r, active_nxt;
	logic [DW-1:0] rdata_r, rdata_nxt;
	logic drive_r, drive_nxt;
	logic [DW-1:0] oe_r;
	logic [ADDR_W-1:0] cur_addr;
	logic [BURST_BITS-1:0] low_bits;
	logic [DW-1:0] wmask;
	logic wr_go;

	// per-lane mask, parity bit travels with its lane
	always_comb begin
		for (int l = 0; l < LANES; l++) begin
			wmask[l*LW +: LW] = {LW{~BYTE_WRITE_N[l]}}; // [R07] [R08] [R10]
		end
	end

	always_comb begin
		base_nxt = base_r;
		cnt_nxt = cnt_r;
		cyc_nxt = cyc_r;
		active_nxt = active_r;
		if (!ADVANCE_LOAD_N) begin
			base_nxt = ADDR; // [R02]
			cnt_nxt = BURST_ZERO;
			active_nxt = 1'b1;
			cyc_nxt.selected = !CHIP_SELECT_N && !CHIP_SELECT_SECOND_N && CHIP_SELECT_HIGH; // [R12]
			cyc_nxt.kind = READ_WRITE_N ? SSB_READ : SSB_WRITE; // [R09]
		end else if (active_r) begin
			cnt_nxt = cnt_r + BURST_STEP; // [R03] [R04]
		end
	end

	// current address of this edge: loaded base with modified low bits
	always_comb begin
		if (!BURST_ORDER_SELECT) begin
			low_bits = base_r[BURST_BITS-1:0] + cnt_nxt; // [R05] [R13]
		end else begin
			low_bits = base_r[BURST_BITS-1:0] ^ cnt_nxt; // [R05] [R13]
		end
		if (!ADVANCE_LOAD_N) begin
			cur_addr = ADDR;
		end else begin
			cur_addr = {base_r[ADDR_W-1:BURST_BITS], low_bits};
		end
	end

	always_comb begin
		wr_go = active_nxt && cyc_nxt.selected && cyc_nxt.kind == SSB_WRITE;
		drive_nxt = active_nxt && cyc_nxt.selected && cyc_nxt.kind == SSB_READ;
		rdata_nxt = drive_nxt ? mem[cur_addr] : rdata_r;
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			base_r <= '0;
			cnt_r <= BURST_ZERO;
			cyc_r <= '{selected: 1'b0, kind: SSB_READ};
			active_r <= 1'b0;
			rdata_r <= '0;
			drive_r <= 1'b0;
		end else if (!CLOCK_ENABLE_N) begin // [R11]
			base_r <= base_nxt;
			cnt_r <= cnt_nxt;
			cyc_r <= cyc_nxt;
			active_r <= active_nxt;
			rdata_r <= rdata_nxt;
			drive_r <= drive_nxt;
		end
	end

	// array has no reset; lanes merged under byte write mask
	always_ff @(posedge CORE_CLK) begin
		if (!CLOCK_ENABLE_N && wr_go) begin // [R11]
			mem[cur_addr] <= (mem[cur_addr] & ~wmask) | (DATA_IN & wmask); // [R10]
		end
	end

	assign DATA_OUT = rdata_r;
	// output enable pin gates drivers without a clock
	always_comb begin
		oe_r = {DW{drive_r && !OUTPUT_ENABLE_N}}; // [R01]
	end
	assign DATA_OE = oe_r;

	// enabled edge that loads a new address
	sequence s_load;
		!ADVANCE_LOAD_N && !CLOCK_ENABLE_N;
	endsequence

	// enabled edge that advances the burst
	sequence s_adv;
		ADVANCE_LOAD_N && !CLOCK_ENABLE_N;
	endsequence

	// advance inside a burst that was loaded
	sequence s_step;
		s_adv ##0 active_r;
	endsequence

	// load of a fully selected read
	sequence s_sel_read;
		s_load ##0 (READ_WRITE_N && !CHIP_SELECT_N && !CHIP_SELECT_SECOND_N && CHIP_SELECT_HIGH);
	endsequence

	chk_oe_async: assert property ( // [R01]
		@(posedge CORE_CLK) disable iff (!RST_B)
		OUTPUT_ENABLE_N |-> DATA_OE == '0)
		else $error("drivers on while disabled");

	chk_read_drive: assert property ( // [R01] [R09] [R12]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_sel_read |=> OUTPUT_ENABLE_N || DATA_OE == '1)
		else $error("selected read not driven");

	chk_load_base: assert property ( // [R02]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_load |=> base_r == $past(ADDR) && cnt_r == BURST_ZERO)
		else $error("address not loaded");

	chk_adv_step: assert property ( // [R03]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_step |=> cnt_r == $past(cnt_r) + BURST_STEP)
		else $error("burst counter did not step");

	chk_adv_base: assert property ( // [R03]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_adv |=> $stable(base_r))
		else $error("base moved while advancing");

	chk_kind_hold: assert property ( // [R04]
		@(posedge CORE_CLK) disable iff (!RST_B)
		ADVANCE_LOAD_N |=> $stable(cyc_r))
		else $error("cycle type changed in burst");

	chk_kind_load: assert property ( // [R09]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_load |=> cyc_r.kind == ($past(READ_WRITE_N) ? SSB_READ : SSB_WRITE))
		else $error("cycle type wrong");

	chk_write_quiet: assert property ( // [R09]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_load ##0 !READ_WRITE_N |=> DATA_OE == '0)
		else $error("write cycle drove the bus");

	chk_select_all: assert property ( // [R12]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_load ##0 CHIP_SELECT_N |=> !cyc_r.selected)
		else $error("selected without chip select");

	chk_select_second: assert property ( // [R12]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_load ##0 CHIP_SELECT_SECOND_N |=> !cyc_r.selected)
		else $error("selected without second select");

	chk_select_high: assert property ( // [R12]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_load ##0 !CHIP_SELECT_HIGH |=> !cyc_r.selected && DATA_OE == '0)
		else $error("selected without high select");

	chk_suspend_hold: assert property ( // [R11]
		@(posedge CORE_CLK) disable iff (!RST_B)
		CLOCK_ENABLE_N |=> $stable(base_r) && $stable(cnt_r) && $stable(DATA_OUT))
		else $error("state moved in suspend");

	chk_suspend_kind: assert property ( // [R11]
		@(posedge CORE_CLK) disable iff (!RST_B)
		CLOCK_ENABLE_N |=> $stable(cyc_r) && $stable(drive_r) && $stable(active_r))
		else $error("cycle state moved in suspend");

	chk_linear_order: assert property ( // [R05] [R13]
		@(posedge CORE_CLK) disable iff (!RST_B)
		ADVANCE_LOAD_N && !BURST_ORDER_SELECT |->
		cur_addr[BURST_BITS-1:0] == BURST_BITS'(base_r[BURST_BITS-1:0] + cnt_nxt))
		else $error("linear order wrong");

	chk_inter_order: assert property ( // [R05] [R13]
		@(posedge CORE_CLK) disable iff (!RST_B)
		ADVANCE_LOAD_N && BURST_ORDER_SELECT |->
		cur_addr[BURST_BITS-1:0] == (base_r[BURST_BITS-1:0] ^ cnt_nxt))
		else $error("interleaved order wrong");

	chk_high_bits: assert property ( // [R13]
		@(posedge CORE_CLK) disable iff (!RST_B)
		ADVANCE_LOAD_N |-> cur_addr[ADDR_W-1:BURST_BITS] == base_r[ADDR_W-1:BURST_BITS])
		else $error("burst touched high address bits");

	chk_burst_wrap: assert property ( // [R13]
		@(posedge CORE_CLK) disable iff (!RST_B)
		s_step ##0 cnt_r == '1 |=> cnt_r == BURST_ZERO)
		else $error("burst counter did not wrap");

	chk_write_mask: assert property ( // [R10]
		@(posedge CORE_CLK) disable iff (!RST_B)
		wr_go && BYTE_WRITE_N == '0 |-> wmask == '1)
		else $error("full write masked");

	chk_read_nowrite: assert property ( // [R10]
		@(posedge CORE_CLK) disable iff (!RST_B)
		drive_nxt |-> !wr_go)
		else $error("read cycle also wrote");
endmodule
`default_nettype wire

// file: verification/ssb_ctrl_model.sv
// controller-side model holding the burst order strap
`timescale 1ns/1ps
`default_nettype none
module ssb_ctrl_model (
	input wire logic clk,
	input wire logic idle,
	input wire logic want,
	output logic order
);
	always_ff @(posedge clk) if (idle) order <= want;
endmodule
`default_nettype wire

// file: verification/sync_sram_burst_port_tb_top.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module sync_sram_burst_port_tb_top;
	logic clk = 0, rst_b = 0, ld_n = 1, rw_n = 1, cke_n = 0, oe_n = 0;
	logic want = 0, idle = 1, order, en = 0, kind = 1, sel = 0;
	logic [2:0] cs = 3'h5, off [3] = '{3'h5, 3'h3, 3'h0};
	logic [5:0] addr = 6'h00, base = 6'h00, ad;
	logic [3:0] bw_n = 4'hF;
	logic [1:0] k = 2'h0;
	logic [7:0] lf = 8'h5E;
	logic [35:0] din = 36'h0, dout, doe, d, mem [64], expq [$];
	int error_cnt = 0, compares = 0;
	always #2.5 clk = ~clk;
	ssb_ctrl_model ssb_ctrl_model_inst (.clk(clk), .idle(idle), .want(want), .order(order));
	ssb_port #(.ADDR_W(6)) ssb_port_inst (.CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr),
		.ADVANCE_LOAD_N(ld_n), .READ_WRITE_N(rw_n), .BYTE_WRITE_N(bw_n), .CLOCK_ENABLE_N(cke_n),
		.CHIP_SELECT_N(cs[2]), .CHIP_SELECT_SECOND_N(cs[1]), .CHIP_SELECT_HIGH(cs[0]),
		.OUTPUT_ENABLE_N(oe_n), .BURST_ORDER_SELECT(order), .DATA_IN(din), .DATA_OUT(dout),
		.DATA_OE(doe));
	task automatic beat(input logic l, r, input logic [5:0] a, input logic [3:0] b,
		input logic [2:0] c, input logic [1:0] m);
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		d = {lf[3:0], lf, ~lf, lf ^ 8'h5A, lf + 8'h33};
		{ld_n, rw_n, addr, bw_n, cs, cke_n, oe_n, din} <= {l, r, a, b, c, m, d};
		if (!m[1]) begin
			if (!l) {base, kind, sel, k} = {a, r, c == 3'h1, 2'h0};
			else k = k + 2'h1;
			ad = {base[5:2], order ? base[1:0] ^ k : base[1:0] + k};
			for (int i = 0; i < 4; i++) if (sel && !kind && !b[i]) mem[ad][i*9 +: 9] = d[i*9 +: 9];
			if (sel && kind && !m[0]) expq.push_back(mem[ad]);
		end
		@(posedge clk);
	endtask
	task automatic burst(input logic r, input logic [5:0] a, input logic [1:0] m);
		beat(0, r, a, 4'h0, 3'h1, m);
		repeat (3) beat(1, !r, 6'h00, 4'h0, 3'h1, m);
	endtask
	task automatic pad(input logic [1:0] m);
		beat(0, 1, 6'h00, 4'hF, 3'h5, m);
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) en = !cke_n && rst_b;
	always @(negedge clk) if (en && doe !== 36'h0) begin
		compares++;
		if (expq.size() == 0 || doe !== '1 || dout !== expq.pop_front()) begin
			$display("mismatch %0t read data", $time);
			error_cnt++;
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1;
		burst(0, 6'h09, 2'h0);
		burst(0, 6'h14, 2'h0);
		beat(0, 0, 6'h0A, 4'h5, 3'h1, 2'h0);
		foreach (off[i]) beat(0, 0, 6'h09, 4'h0, off[i], 2'h0);
		beat(1, 0, 6'h00, 4'h0, 3'h0, 2'h0);
		$display("write tests done");
		burst(1, 6'h09, 2'h0);
		beat(0, 1, 6'h14, 4'h0, 3'h1, 2'h0);
		repeat (2) beat(1, 1, 6'h00, 4'h0, 3'h1, 2'h2);
		repeat (3) beat(1, 1, 6'h00, 4'h0, 3'h1, 2'h0);
		pad(2'h0);
		burst(1, 6'h14, 2'h1);
		{want, idle} <= 2'h3;
		repeat (2) pad(2'h1);
		idle <= 0;
		burst(1, 6'h15, 2'h0);
		pad(2'h0);
		$display("read tests done");
		compares++;
		if (expq.size() != 0) begin
			$display("mismatch %0t reads missing", $time);
			error_cnt++;
		end
		report_and_stop();
	end
	initial begin
		#3000;
		error_cnt++;
		report_and_stop();
	end
endmodule
`default_nettype wire
